// file: mrr_pkg.sv
/*
  Package for the move/rotate/return execution block: encodings, field
  positions, reset values and shared carrier types.
  Assumes a 12-bit instruction word and an 8-bit data path.
*/
package mrr_pkg;

  // ==========================================================
  // Widths and field positions
  localparam int INSN_W    = 12;
  localparam int DATA_W    = 8;
  localparam int FIDX_W    = 5;
  localparam int PC_W      = 9;
  localparam int DEST_BIT  = 5;
  localparam int FIDX_LSB  = 0;

  // ==========================================================
  // Opcode patterns
  localparam logic [11:0] OP_NOP       = 12'h000;
  localparam logic [11:0] OP_OPTION    = 12'h002;
  localparam logic [6:0]  OP_STORE_HI  = 7'h01;   // 0000 001f ffff
  localparam logic [5:0]  OP_ROTL_HI   = 6'h0d;   // 0011 01df ffff
  localparam logic [5:0]  OP_ROTR_HI   = 6'h0c;   // 0011 00df ffff
  localparam logic [3:0]  OP_RETLIT_HI = 4'h8;    // 1000 kkkk kkkk

  // ==========================================================
  // Reset values and cycle counts
  localparam logic [7:0]  W_RST        = 8'h00;
  localparam logic [7:0]  OPTION_RST   = 8'hff;
  localparam logic [PC_W-1:0] PC_RST   = 9'h1ff;
  localparam int          RET_CYCLES   = 2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    MRR_NOP, MRR_OPTION, MRR_STORE, MRR_ROTL, MRR_ROTR, MRR_RETLIT, MRR_OTHER
  } mrr_op_t;

  typedef struct packed {
    mrr_op_t     op;
    logic        dest;
    logic [4:0]  fidx;
    logic [7:0]  lit;
  } mrr_dec_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [7:0]  data;
  } mrr_fwr_t;

endpackage

// file: mrr_decode.sv
/*
  Combinational decoder for the six covered instructions.
  Assumes the instruction word is stable for the whole execute cycle.
*/
`timescale 1ns/10ps
module mrr_decode
  import mrr_pkg::*;
(
  input  wire logic [11:0]       insn,
  output mrr_pkg::mrr_dec_t      dec
);

  // ==========================================================
  // Field split and opcode match
  always_comb begin
    dec.lit  = insn[7:0];
    dec.fidx = insn[FIDX_LSB +: FIDX_W];
    dec.dest = insn[DEST_BIT];
    if (insn == OP_NOP) begin
      dec.op = MRR_NOP;
    end else if (insn == OP_OPTION) begin
      dec.op = MRR_OPTION;
    end else if (insn[11:5] == OP_STORE_HI) begin
      dec.op = MRR_STORE;
    end else if (insn[11:6] == OP_ROTL_HI) begin
      dec.op = MRR_ROTL;
    end else if (insn[11:6] == OP_ROTR_HI) begin
      dec.op = MRR_ROTR;
    end else if (insn[11:8] == OP_RETLIT_HI) begin
      dec.op = MRR_RETLIT;
    end else begin
      dec.op = MRR_OTHER;
    end
  end

endmodule

// file: mrr_exec.sv
/*
  Execution unit for store-W, no-op, load-option, return-with-literal
  and both rotates through carry.
  Assumes: the fetch stage presents INSN with INSN_VALID, holds it while
  BUSY is high, and FILE_RDATA is the combinational read of the file
  register addressed by the instruction's index. Writes to the file
  register and carry leave here as registered strobes.
*/
// Contract
// - Load-option copies W into the option register in one cycle, flags kept.
// - Return-with-literal loads W with k and PC from stack_top over two cycles, flags kept.
// - Rotate-left shifts the file value left, old carry to bit 0, old bit 7 to carry.
// - Rotate-left with destination one writes the file register, zero writes W.
// - Rotate-left alters only the carry flag and takes one cycle.
// - Rotate-right shifts right, old carry to bit 7, old bit 0 to carry, in one cycle.
// - Rotate-right with destination zero writes W and spares the file, one writes the file.
// - Rotates address file registers 0 to 31 through a 5-bit index.
`timescale 1ns/10ps
module mrr_exec
  import mrr_pkg::*;
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESETN,
  input  wire logic                   INSN_VALID,
  input  wire logic [11:0]            INSN,
  input  wire logic [7:0]             FILE_RDATA,
  input  wire logic                   CARRY_IN,
  input  wire logic [mrr_pkg::PC_W-1:0] STACK_TOP,
  output mrr_pkg::mrr_fwr_t           FILE_WR,
  output logic                        CARRY_WE,
  output logic                        CARRY_OUT,
  output logic [7:0]                  W_REG,
  output logic [7:0]                  OPTION_REG,
  output logic [mrr_pkg::PC_W-1:0]    PC,
  output logic                        STACK_POP,
  output logic                        BUSY
);
  import mrr_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [0:0] {ST_RUN, ST_FLUSH} mrr_st_t;

  typedef struct packed {
    mrr_st_t          st;
    logic [7:0]       w;
    logic [7:0]       option;
    logic [PC_W-1:0]  pc;
    mrr_fwr_t         fwr;
    logic             carry_we;
    logic             carry;
    logic             pop;
    logic             busy;
  } mrr_state_t;

  mrr_state_t  cur;
  mrr_state_t  next_cur;
  mrr_dec_t    dec;

  mrr_decode u_dec (
    .insn (INSN),
    .dec  (dec)
  );

  function automatic logic [8:0] rot_left(input logic [7:0] v,
                                          input logic c);
    rot_left = {v[7], v[6:0], c};
  endfunction

  function automatic logic [8:0] rot_right(input logic [7:0] v,
                                           input logic c);
    rot_right = {v[0], c, v[7:1]};
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [8:0] r;
    r = 9'h000;
    next_cur = cur;
    next_cur.fwr.we   = 1'b0;
    next_cur.carry_we = 1'b0;
    next_cur.pop      = 1'b0;
    next_cur.busy     = 1'b0;
    case (cur.st)
      ST_FLUSH: begin
        // Second cycle of a return discards the fetched word
        next_cur.st = ST_RUN;
      end
      ST_RUN: begin
        if (INSN_VALID) begin
          next_cur.pc = cur.pc + 9'h001;
          case (dec.op)
            MRR_NOP: begin
              next_cur.pc = cur.pc + 9'h001;
            end
            MRR_OPTION: begin
              next_cur.option = cur.w;
            end
            MRR_STORE: begin
              next_cur.fwr = '{we: 1'b1, addr: dec.fidx, data: cur.w};
            end
            MRR_ROTL, MRR_ROTR: begin
              r = (dec.op == MRR_ROTL) ? rot_left(FILE_RDATA, CARRY_IN)
                                      : rot_right(FILE_RDATA, CARRY_IN);
              // Carry is the only flag written
              next_cur.carry_we = 1'b1;
              next_cur.carry    = r[8];
              if (dec.dest) begin
                next_cur.fwr = '{we: 1'b1, addr: dec.fidx, data: r[7:0]};
              end else begin
                next_cur.w = r[7:0];
              end
            end
            MRR_RETLIT: begin
              // Literal to W, PC from stack top
              next_cur.w   = dec.lit;
              next_cur.pc  = STACK_TOP;
              next_cur.pop = 1'b1;
              next_cur.st  = ST_FLUSH;
              // Busy kept as its own flop so the pin has no decode
              next_cur.busy = 1'b1;
            end
            default: begin
              // Other instructions belong to other units
              next_cur.pc = cur.pc + 9'h001;
            end
          endcase
        end
      end
      default: next_cur.st = ST_RUN;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= '{st: ST_RUN, w: W_RST, option: OPTION_RST, pc: PC_RST,
               fwr: '0, carry_we: 1'b0, carry: 1'b0, pop: 1'b0,
               busy: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign FILE_WR    = cur.fwr;
  assign CARRY_WE   = cur.carry_we;
  assign CARRY_OUT  = cur.carry;
  assign W_REG      = cur.w;
  assign OPTION_REG = cur.option;
  assign PC         = cur.pc;
  assign STACK_POP  = cur.pop;
  assign BUSY       = cur.busy;

  // ==========================================================
  // Checks
  sequence s_ret_issue;
    INSN_VALID && !BUSY && dec.op == MRR_RETLIT;
  endsequence

  a_option_load: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_OPTION) |=>
      OPTION_REG == $past(W_REG) && !CARRY_WE)
    else $error("option load wrong");

  a_ret_two: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    s_ret_issue |=> BUSY && PC == $past(STACK_TOP) && !CARRY_WE
      ##1 !BUSY)
    else $error("return sequence wrong");

  a_rotl_value: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_ROTL) |=>
      CARRY_WE && CARRY_OUT == $past(FILE_RDATA[7]))
    else $error("rotate left carry wrong");

  a_rotl_dest: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_ROTL && dec.dest) |=>
      FILE_WR.we && FILE_WR.data == {$past(FILE_RDATA[6:0]),
      $past(CARRY_IN)})
    else $error("rotate left file write wrong");

  a_rotl_flags: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_ROTL) |=>
      !BUSY && !STACK_POP && $stable(OPTION_REG))
    else $error("rotate left took extra cycle");

  a_rotr_value: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_ROTR) |=>
      CARRY_WE && CARRY_OUT == $past(FILE_RDATA[0]))
    else $error("rotate right carry wrong");

  a_rotr_dest: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_ROTR && !dec.dest) |=>
      !FILE_WR.we && W_REG == {$past(CARRY_IN),
      $past(FILE_RDATA[7:1])})
    else $error("rotate right to W wrong");

  a_rot_index: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op inside {MRR_ROTL, MRR_ROTR} && dec.dest)
      |=> FILE_WR.addr == $past(INSN[4:0]))
    else $error("rotate index wrong");

  a_store_w: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_STORE) |=>
      FILE_WR.we && FILE_WR.data == $past(W_REG) && !CARRY_WE)
    else $error("store W wrong");

  a_nop_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (INSN_VALID && !BUSY && dec.op == MRR_NOP) |=>
      !FILE_WR.we && !CARRY_WE && $stable(W_REG) &&
      PC == $past(PC) + 9'h001)
    else $error("nop changed state");

endmodule

// file: tb_move_rotate_return_ops.sv
/*
  Self-checking bench for mrr_exec: an integer model predicts every result.
  Assumes the file registers and carry live in the bench as model state.
*/
`timescale 1ns/10ps
module tb_move_rotate_return_ops;
  import mrr_pkg::*;

  logic            core_clk;
  logic            resetn;
  logic            insn_valid;
  logic [11:0]     insn;
  logic [7:0]      file_rdata;
  logic            carry_in;
  logic [PC_W-1:0] stack_top;
  mrr_fwr_t        file_wr;
  logic            carry_we;
  logic            carry_out;
  logic [7:0]      w_reg;
  logic [7:0]      option_reg;
  logic [PC_W-1:0] pc;
  logic            stack_pop;
  logic            busy;
  int              miscompares = 0;
  int              checked = 0;
  logic [31:0]     rnd = 32'h325b;
  int              m_mem[32];
  int              mw, mopt, mpc, mc;
  int              e_we, e_addr, e_data, e_cwe, e_cout;
  logic [11:0]     dir[10];

  mrr_exec uut (
    .CORE_CLK  (core_clk),
    .RESETN    (resetn),
    .INSN_VALID(insn_valid),
    .INSN      (insn),
    .FILE_RDATA(file_rdata),
    .CARRY_IN  (carry_in),
    .STACK_TOP (stack_top),
    .FILE_WR   (file_wr),
    .CARRY_WE  (carry_we),
    .CARRY_OUT (carry_out),
    .W_REG     (w_reg),
    .OPTION_REG(option_reg),
    .PC        (pc),
    .STACK_POP (stack_pop),
    .BUSY      (busy)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input int exp, input string s);
    checked++;
    if (got !== exp[8:0]) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp[8:0]);
    end
  endtask

  // Compares the outputs left by the previous instruction
  task automatic check_pend();
    chk(9'(file_wr.we), e_we, "file we");
    if (e_we == 1) begin
      chk(9'(file_wr.addr), e_addr, "file addr");
      chk(9'(file_wr.data), e_data, "file data");
    end
    chk(9'(carry_we), e_cwe, "carry we");
    if (e_cwe == 1)
      chk(9'(carry_out), e_cout, "carry");
    chk(9'(w_reg), mw, "w");
    chk(9'(option_reg), mopt, "option");
    chk(pc, mpc, "pc");
    chk(9'(busy), 0, "busy");
    chk(9'(stack_pop), 0, "pop");
  endtask

  // ==========================================================
  // One instruction, entered at a rising edge; model runs ahead
  task automatic step(input logic [11:0] i);
    int f, r;
    logic [PC_W-1:0] top;
    rnd = lfsr(rnd);
    top = rnd[PC_W-1:0];
    f = int'(i[4:0]);
    insn <= i;
    insn_valid <= 1'b1;
    stack_top <= top;
    file_rdata <= 8'(m_mem[f]);
    carry_in <= mc[0];
    #1;
    check_pend();
    e_we = 0;
    e_cwe = 0;
    mpc = (mpc + 1) & 511;
    if (i == OP_OPTION)
      mopt = mw;
    else if (i[11:5] == OP_STORE_HI) begin
      e_we = 1; e_addr = f; e_data = mw; m_mem[f] = mw;
    end else if (i[11:6] == OP_ROTL_HI || i[11:6] == OP_ROTR_HI) begin
      if (i[6]) begin
        r = ((m_mem[f] << 1) | mc) & 255;
        e_cout = m_mem[f] >> 7;
      end else begin
        r = (m_mem[f] >> 1) | (mc << 7);
        e_cout = m_mem[f] & 1;
      end
      mc = e_cout;
      e_cwe = 1;
      if (i[DEST_BIT]) begin
        e_we = 1; e_addr = f; e_data = r; m_mem[f] = r;
      end else
        mw = r;
    end else if (i[11:8] == OP_RETLIT_HI) begin
      mw = int'(i[7:0]);
      mpc = int'(top);
    end
    @(posedge core_clk);
    if (i[11:8] == OP_RETLIT_HI) begin
      // Second cycle: a fresh word must be ignored
      rnd = lfsr(rnd);
      insn <= rnd[11:0];
      #1;
      chk(9'(busy), 1, "busy");
      chk(9'(stack_pop), 1, "pop");
      @(posedge core_clk);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    insn_valid = 1'b0;
    insn = 12'h000;
    file_rdata = 8'h00;
    carry_in = 1'b0;
    stack_top = 9'h000;
    mw = int'(W_RST);
    mopt = int'(OPTION_RST);
    mpc = int'(PC_RST);
    mc = 0;
    e_we = 0;
    e_cwe = 0;
    for (int k = 0; k < 32; k++) begin
      rnd = lfsr(rnd);
      m_mem[k] = int'(rnd[7:0]);
    end
    dir = '{12'h8e6, OP_OPTION, 12'h020, 12'h03f, 12'h340,
            12'h37f, 12'h31f, 12'h320, 12'h8ff, 12'h800};
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (dir[k])
      step(dir[k]);
    step(OP_NOP);
    repeat (400) begin
      rnd = lfsr(rnd);
      step(rnd[11:0]);
    end
    insn_valid <= 1'b0;
    #1;
    check_pend();
    // Idle cycle: nothing may move, not even the PC
    e_we = 0;
    e_cwe = 0;
    @(posedge core_clk);
    #1;
    check_pend();
    conclude();
  end

  // Around 450 cycles expected; far beyond that is a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
